// File: dv/ruf_ctrl_bench.sv
`timescale 1ns/100ps
module ruf_ctrl_bench;
   // clock, reset and bus
   logic        mclk;
   logic        rst_b;
   logic [5:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   // slow clock and neighbours
   logic        clk32_pin;
   logic        blk_en;
   logic        alarm_evt;
   logic        dst_fwd_hit;
   logic        dst_bwd_hit;
   // conversion and calendar outputs
   logic [6:0]  cal_int_val;
   logic        cal_is_hour;
   logic [7:0]  host_ext_val;
   logic [7:0]  host_pres_val_reg;
   logic [6:0]  cal_wr_val_reg;
   logic        time_adv_reg;
   logic        dst_fwd_reg;
   logic        dst_bwd_reg;
   logic        uip_reg;
   logic        irq_reg;
   // bench bookkeeping
   int          bad_count;
   int          checks;
   logic [31:0] cyc;
   logic [31:0] adv_n;
   logic [31:0] adv_cyc;
   logic [31:0] uip_n;
   logic [31:0] uip_rise;
   logic        uip_prev;
   logic        fwd_seen;
   logic        bwd_seen;
   logic [7:0]  rdat;

   ruf_ctrl u_ruf_ctrl (.mclk(mclk), .rst_b(rst_b), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .clk32_pin(clk32_pin), .blk_en(blk_en), .alarm_evt(alarm_evt),
      .dst_fwd_hit(dst_fwd_hit), .dst_bwd_hit(dst_bwd_hit), .cal_int_val(cal_int_val),
      .cal_is_hour(cal_is_hour), .host_ext_val(host_ext_val),
      .host_pres_val_reg(host_pres_val_reg), .cal_wr_val_reg(cal_wr_val_reg),
      .time_adv_reg(time_adv_reg), .dst_fwd_reg(dst_fwd_reg), .dst_bwd_reg(dst_bwd_reg),
      .uip_reg(uip_reg), .irq_reg(irq_reg));

   ////////////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial
   begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // slow clock sped up to one tick per two cycles so a restart fits the run
   always @(posedge mclk)
      clk32_pin <= ~clk32_pin;

   // watch calendar strobes and the pending flag
   always @(posedge mclk)
   begin
      cyc <= cyc + 32'h1;   // late update so every reader sees the same count
      if (time_adv_reg === 1'b1)
      begin
         adv_n = adv_n + 32'h1;
         adv_cyc = cyc;
         fwd_seen = dst_fwd_reg;
         bwd_seen = dst_bwd_reg;
      end
      if (uip_reg === 1'b1 && uip_prev !== 1'b1)
         uip_rise = cyc;
      if (uip_reg === 1'b1)
         uip_n = uip_n + 32'h1;
      uip_prev = uip_reg;
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic wait_n(input int n);
      repeat (n) @(posedge mclk);
   endtask : wait_n

   // one avalon transfer; held until waitrequest is sampled low
   task automatic bus(input logic wr, input logic [5:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge mclk);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= ~wr;
      avs_writedata <= {24'h0, d};
      do
      begin
         @(posedge mclk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         chk("bus answer", 32'h0, 32'h1);
         summarize;
      end
      rdat = avs_readdata[7:0];
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus

   task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      chk(what, {24'h0, rdat}, {24'h0, exp});
   endtask : rd_chk

   // host form of an internal value: bcd or binary, 12-hour with pm in bit 7
   function automatic logic [7:0] fmt(input logic [6:0] v, input logic bin, input logic h24,
                                      input logic hr);
      logic [6:0] h;
      logic       pm;
      h  = v;
      pm = 1'b0;
      if (hr && !h24)
      begin
         pm = (v >= 7'h0c);
         h  = (v % 7'h0c == 7'h00) ? 7'h0c : v % 7'h0c;
      end
      fmt = bin ? {pm, h} : {pm, 3'(h / 7'h0a), 4'(h % 7'h0a)};
   endfunction : fmt

   // wait for irq with a bound, then note the cycle
   task automatic wait_irq(output logic [31:0] t);
      int n;
      n = 0;
      while (irq_reg !== 1'b1 && n < 3000)
      begin
         @(posedge mclk);
         n++;
      end
      if (n >= 3000)
      begin
         chk("irq wait", 32'h0, 32'h1);
         summarize;
      end
      t = cyc;
   endtask : wait_irq

   task automatic summarize;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : summarize

   // hang guard, a little beyond the whole run of all sequences
   initial
   begin
      repeat (95000) @(posedge mclk);
      bad_count++;
      $display("Error watchdog expected finish seen hang");
      summarize;
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin : main
      logic [6:0]  vals [6];
      logic [31:0] t0;
      logic [31:0] t1;
      logic [31:0] base;
      logic [31:0] per;
      vals = '{7'h00, 7'h09, 7'h0c, 7'h0d, 7'h17, 7'h2d};
      {rst_b, avs_read, avs_write, clk32_pin, blk_en, alarm_evt} = 6'h0;
      {dst_fwd_hit, dst_bwd_hit, cal_is_hour} = 3'h0;
      {avs_address, avs_writedata, cal_int_val, host_ext_val} = '0;
      {bad_count, checks} = '0;
      {cyc, adv_n, adv_cyc, uip_n, uip_rise} = '0;
      {uip_prev, fwd_seen, bwd_seen, rdat} = '0;
      wait_n(6);
      rst_b  <= 1'b1;
      // reset values, reserved and read-only bits, unmapped place
      rd_chk("rate reset", 6'h28, 8'h00);
      rd_chk("irqf reset", 6'h2c, 8'h00);
      rd_chk("flag reset", 6'h30, 8'h00);
      bus(1'b1, 6'h28, 8'hff);
      blk_en <= 1'b1;
      rd_chk("rate ro bit", 6'h28, 8'h7f);
      bus(1'b1, 6'h2c, 8'hff);
      rd_chk("irqf reserved", 6'h2c, 8'hf7);
      bus(1'b1, 6'h3c, 8'hff);
      rd_chk("unmapped", 6'h3c, 8'h00);
      $display("test registers done");
      // every mode pair on hours and a plain field, both directions
      for (int m = 0; m < 4; m++)
      begin
         bus(1'b1, 6'h2c, {5'h0, m[1], m[0], 1'b0});
         for (int i = 0; i < 6; i++)
         begin
            @(posedge mclk);
            cal_is_hour  <= (i < 5);
            cal_int_val  <= vals[i];
            host_ext_val <= fmt(vals[i], m[1], m[0], i < 5);
            wait_n(3);
            chk("read form", {24'h0, host_pres_val_reg},
                {24'h0, fmt(vals[i], m[1], m[0], i < 5)});
            chk("write form", {25'h0, cal_wr_val_reg}, {25'h0, vals[i]});
         end
      end
      $display("test conversion done");
      // periodic gaps, measured between two gated interrupts
      bus(1'b1, 6'h2c, 8'h40);
      // first wait only aligns: an event inside the read may leave irq standing
      for (int c = 1; c < 10; c++)
      begin
         bus(1'b1, 6'h28, {4'h2, 4'(c)});
         for (int k = 0; k < 2; k++)
         begin
            bus(1'b0, 6'h30, 8'h00);
            wait_n(3);
            wait_irq(t1);
         end
         bus(1'b0, 6'h30, 8'h00);
         wait_n(3);
         wait_irq(t0);
         per = (c < 3) ? (32'h1 << (c + 6)) : (32'h1 << (c - 1));
         chk("periodic gap", t0 - t1, per * 32'h2);
      end
      // gate closed: flag still records, summary stays low
      bus(1'b1, 6'h2c, 8'h00);
      bus(1'b0, 6'h30, 8'h00);
      wait_n(600);
      chk("periodic ungated irq", {31'h0, irq_reg}, 32'h0);
      rd_chk("periodic flag", 6'h30, 8'h40);
      bus(1'b1, 6'h28, 8'h20);
      bus(1'b0, 6'h30, 8'h00);
      wait_n(600);
      rd_chk("rate zero silent", 6'h30, 8'h00);
      $display("test periodic done");
      // alarm gated off, then on
      for (int g = 0; g < 2; g++)
      begin
         bus(1'b1, 6'h2c, {2'h0, g[0], 5'h0});
         @(posedge mclk);
         alarm_evt <= 1'b1;
         @(posedge mclk);
         alarm_evt <= 1'b0;
         wait_n(4);
         chk("alarm irq", {31'h0, irq_reg}, {31'h0, g[0]});
         rd_chk("alarm flag", 6'h30, {g[0], 7'h20});
         wait_n(3);
         chk("irq after clear", {31'h0, irq_reg}, 32'h0);
      end
      $display("test alarm done");
      // halt holds, freeze suppresses a whole restart interval
      bus(1'b1, 6'h2c, 8'h80);
      bus(1'b1, 6'h28, 8'h70);
      base = adv_n + uip_n;
      wait_n(300);
      chk("halted", adv_n + uip_n, base);
      bus(1'b1, 6'h28, 8'h20);
      wait_n(33500);
      chk("frozen", adv_n + uip_n, base);
      $display("test freeze done");
      // restart with enable dropped for 1000 ticks
      bus(1'b1, 6'h28, 8'h70);
      bus(1'b1, 6'h2c, 8'h11);
      bus(1'b0, 6'h30, 8'h00);
      @(posedge mclk);
      dst_fwd_hit <= 1'b1;
      base = adv_n;
      bus(1'b1, 6'h28, 8'h20);
      t0 = cyc;
      wait_n(4000);
      blk_en <= 1'b0;
      wait_n(2000);
      blk_en <= 1'b1;
      while (adv_n == base && cyc - t0 < 40000)
         @(posedge mclk);
      t1 = adv_cyc - t0;
      chk("restart delay", {31'h0, t1 > 34760 && t1 < 34776}, 32'h1);
      chk("pending lead", {31'h0, adv_cyc - uip_rise > 30 && adv_cyc - uip_rise < 36},
          32'h1);
      chk("dst strobes", {30'h0, fwd_seen, bwd_seen}, 32'h2);
      wait_n(3);
      chk("pending cleared", {31'h0, uip_reg}, 32'h0);
      chk("update irq", {31'h0, irq_reg}, 32'h1);
      rd_chk("update flag", 6'h30, 8'h90);
      $display("test restart done");
      summarize;
   end
endmodule : ruf_ctrl_bench

// File: verilog/ruf_ctrl.sv
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "ruf_regs.svh"
// What this block does
// - update-pending flag rises 16 slow ticks before each update, falls right after
// - divider field 11x halts time and date advancing
// - first 010 write after halt gives first update 500 ms later
// - counting only with divider field 010 and block enable set
// - rate code picks periodic event period, 0 never fires
// - with freeze clear, time and date advance once per second
// - freeze bit set suppresses hardware updates; clearing resumes them
// - periodic event reaches interrupt only while its gate is set
// - alarm event reaches interrupt only while its gate is set
// - update-done event reaches interrupt only while its gate is set
// - format bit selects binary or BCD for reads and writes
// - hour style bit selects 24-hour or 12-hour with am/pm bit
// - summer-time bit enables yearly forward and backward hour adjust
// - format bits only change conversion, never stored contents
// - format bits may change any time, conversion follows on the next cycle
// - flags record regardless of gates; summary ORs gated flags; read clears
// - update-done flag set by every update pulse, once a second unless frozen
// - hours alarm writes follow current format and hour style
module ruf_ctrl
(
   // clock and reset
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // avalon-mm slave
   input  wire logic [5:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // slow clock pin
   input  wire logic        clk32_pin,
   // neighbouring control and calendar logic
   input  wire logic        blk_en,
   input  wire logic        alarm_evt,
   input  wire logic        dst_fwd_hit,
   input  wire logic        dst_bwd_hit,
   // format conversion ports
   input  wire logic [6:0]  cal_int_val,
   input  wire logic        cal_is_hour,
   input  wire logic [7:0]  host_ext_val,
   output logic      [7:0]  host_pres_val_reg,
   output logic      [6:0]  cal_wr_val_reg,
   // outputs to calendar counters
   output logic             time_adv_reg,
   output logic             dst_fwd_reg,
   output logic             dst_bwd_reg,
   output logic             uip_reg,
   output logic             irq_reg
);
   localparam int DIV_W = 15;

   logic                 clk32_s;
   logic                 clk32_d_reg;
   logic                 tick;
   logic [DIV_W-1:0]     div_reg;
   logic [DIV_W-1:0]     div_next;
   logic [DIV_W-1:0]     per_mask;
   logic                 counting;
   logic                 wrap;
   logic                 per_evt;
   logic [2:0]           dcs_reg;
   logic [3:0]           rate_reg;
   logic                 freeze_reg;
   logic                 pie_reg;
   logic                 aie_reg;
   logic                 uie_reg;
   logic                 bin_reg;
   logic                 h24_reg;
   logic                 dst_reg;
   logic                 pf_reg;
   logic                 af_reg;
   logic                 uf_reg;
   logic [2:0]           snap_reg;
   logic                 rd_acc;
   logic                 wr_acc;
   logic [3:0]           idx;
   logic [7:0]           wbyte;
   logic [7:0]           rbyte;
   logic                 irq_sum;
   logic [7:0]           pres_val;
   logic [6:0]           wr_val;
   ruf_pkg::ruf_chain_t  chain_reg;

   ////////////////////////////////////////////////////////////////////////////
   // slow clock pin: synchronised, then a rising edge is one tick
   ruf_sync2 u_sync
   (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     (clk32_pin),
      .q     (clk32_s)
   );

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         clk32_d_reg <= 1'b0;
      else
         clk32_d_reg <= clk32_s;
   end

   assign tick = clk32_s && !clk32_d_reg;

   ////////////////////////////////////////////////////////////////////////////
   // bus decode; one wait cycle, accept on the cycle with waitrequest low
   assign idx    = avs_address[5:2];
   assign wbyte  = avs_writedata[7:0];
   assign rd_acc = avs_read && !avs_waitrequest;
   assign wr_acc = avs_write && !avs_waitrequest;

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         avs_waitrequest <= 1'b1;
      else if (avs_waitrequest && (avs_read || avs_write))
         avs_waitrequest <= 1'b0;
      else
         avs_waitrequest <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // divider chain: runs on 010 plus block enable only
   assign counting = tick && (dcs_reg == `RUF_DCS_RUN) && blk_en;
   assign div_next = div_reg + 15'h0001;
   assign wrap     = counting && (div_reg == `RUF_DIV_TOP);

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         div_reg <= '0;
      else if (wr_acc && idx == `RUF_IDX_RATE && wbyte[`RUF_A_DCS] == `RUF_DCS_RUN
               && chain_reg == ruf_pkg::RUF_CH_HALT)
         div_reg <= DIV_W'(`RUF_DIV_TOP + 1 - `RUF_RESTART_TICKS);
      else if (dcs_reg[`RUF_DCS_HALT] == `RUF_HALT_CODE)
         div_reg <= '0;
      else if (counting)
         div_reg <= div_next;
   end

   // halt history: only the first 010 after a halt restarts half way
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         chain_reg <= ruf_pkg::RUF_CH_STOP;
      else if (wr_acc && idx == `RUF_IDX_RATE)
      begin
         if (wbyte[`RUF_A_HALT] == `RUF_HALT_CODE)
            chain_reg <= ruf_pkg::RUF_CH_HALT;
         else if (wbyte[`RUF_A_DCS] == `RUF_DCS_RUN)
            chain_reg <= ruf_pkg::RUF_CH_RUN;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // periodic rate: codes 1 and 2 alias 8 and 9
   function automatic logic [3:0] rate_exp(input logic [3:0] r);
      case (r)
         4'h0:    return 4'h0;
         4'h1:    return 4'h7;
         4'h2:    return 4'h8;
         default: return r - 4'h1;
      endcase
   endfunction : rate_exp

   assign per_mask = DIV_W'((32'h1 << rate_exp(rate_reg)) - 32'h1);
   assign per_evt  = counting && (rate_reg != 4'h0)
                     && ((div_next & per_mask) == '0);

   ////////////////////////////////////////////////////////////////////////////
   // update pulse once a second unless frozen; summer-time hour moves ride it
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         time_adv_reg <= 1'b0;
         dst_fwd_reg  <= 1'b0;
         dst_bwd_reg  <= 1'b0;
      end
      else
      begin
         time_adv_reg <= wrap && !freeze_reg;
         dst_fwd_reg  <= wrap && !freeze_reg && dst_reg && dst_fwd_hit;
         dst_bwd_reg  <= wrap && !freeze_reg && dst_reg && dst_bwd_hit;
      end
   end

   // pending flag: set a fixed lead before wrap, cleared by the update itself
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         uip_reg <= 1'b0;
      else if (time_adv_reg || freeze_reg || dcs_reg != `RUF_DCS_RUN)
         uip_reg <= 1'b0;
      else if (counting && div_reg == DIV_W'(`RUF_DIV_TOP - `RUF_UIP_LEAD_TICKS))
         uip_reg <= 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // control register writes; pending flag is not writable
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         dcs_reg  <= `RUF_DCS_RST;
         rate_reg <= 4'h0;
      end
      else if (wr_acc && idx == `RUF_IDX_RATE)
      begin
         dcs_reg  <= wbyte[`RUF_A_DCS];
         rate_reg <= wbyte[`RUF_A_RATE];
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         {freeze_reg, pie_reg, aie_reg, uie_reg, bin_reg, h24_reg, dst_reg} <= '0;
      else if (wr_acc && idx == `RUF_IDX_IRQF)
      begin
         freeze_reg <= wbyte[`RUF_B_FREEZE];
         pie_reg    <= wbyte[`RUF_B_PIE];
         aie_reg    <= wbyte[`RUF_B_AIE];
         uie_reg    <= wbyte[`RUF_B_UIE];
         bin_reg    <= wbyte[`RUF_B_BIN];
         h24_reg    <= wbyte[`RUF_B_H24];
         dst_reg    <= wbyte[`RUF_B_DST];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event flags: read clears only what the read showed, so set wins
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         {pf_reg, af_reg, uf_reg} <= 3'h0;
      else
      begin
         pf_reg <= (pf_reg && !(rd_acc && idx == `RUF_IDX_FLAG && snap_reg[2])) || per_evt;
         af_reg <= (af_reg && !(rd_acc && idx == `RUF_IDX_FLAG && snap_reg[1])) || alarm_evt;
         uf_reg <= (uf_reg && !(rd_acc && idx == `RUF_IDX_FLAG && snap_reg[0]))
                   || time_adv_reg;
      end
   end

   assign irq_sum = (pf_reg && pie_reg) || (af_reg && aie_reg)
                    || (uf_reg && uie_reg);

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         irq_reg <= 1'b0;
      else
         irq_reg <= irq_sum;
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data captured in the wait cycle; unmapped words read zero
   always_comb
   begin
      case (idx)
         `RUF_IDX_RATE: rbyte = {uip_reg, dcs_reg, rate_reg};
         `RUF_IDX_IRQF: rbyte = {freeze_reg, pie_reg, aie_reg, uie_reg,
                                 1'b0, bin_reg, h24_reg, dst_reg};
         `RUF_IDX_FLAG: rbyte = {irq_sum, pf_reg, af_reg, uf_reg, 4'h0};
         default:       rbyte = `RUF_RST_BYTE;
      endcase
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         avs_readdata <= 32'h0;
         snap_reg     <= 3'h0;
      end
      else if (avs_read && avs_waitrequest)
      begin
         avs_readdata <= {24'h0, rbyte};
         snap_reg     <= {pf_reg, af_reg, uf_reg};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // host-side conversion; storage stays binary 24-hour
   ruf_fmt u_fmt
   (
      .bin_mode (bin_reg),
      .h24      (h24_reg),
      .is_hour  (cal_is_hour),
      .int_val  (cal_int_val),
      .ext_out  (pres_val),
      .ext_in   (host_ext_val),
      .int_out  (wr_val)
   );

   // one register stage; mode changes apply on the next cycle
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         host_pres_val_reg <= 8'h00;
         cal_wr_val_reg    <= 7'h00;
      end
      else
      begin
         host_pres_val_reg <= pres_val;
         cal_wr_val_reg    <= wr_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence s_req;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence

   sequence s_ack;
      !avs_waitrequest ##1 avs_waitrequest;
   endsequence

   AST_BUS_ONE_WAIT: assert property (@(posedge mclk) disable iff (!rst_b)
      s_req |=> s_ack)
      else $error("waitrequest not low for exactly one cycle");

   AST_UIP_LEAD: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(uip_reg) |-> div_reg == DIV_W'(`RUF_DIV_TOP + 1 - `RUF_UIP_LEAD_TICKS))
      else $error("pending flag rose at wrong divider position");

   AST_UIP_FALL: assert property (@(posedge mclk) disable iff (!rst_b)
      time_adv_reg |=> !uip_reg)
      else $error("pending flag still set after update");

   AST_HALT_NO_ADV: assert property (@(posedge mclk) disable iff (!rst_b)
      dcs_reg[`RUF_DCS_HALT] == `RUF_HALT_CODE
      ##1 dcs_reg[`RUF_DCS_HALT] == `RUF_HALT_CODE |-> !time_adv_reg)
      else $error("update while halted");

   AST_RESTART_HALF: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_acc && idx == `RUF_IDX_RATE && wbyte[`RUF_A_DCS] == `RUF_DCS_RUN
      && chain_reg == ruf_pkg::RUF_CH_HALT
      |=> div_reg == DIV_W'(`RUF_DIV_TOP + 1 - `RUF_RESTART_TICKS))
      else $error("restart did not load half second");

   AST_FREEZE: assert property (@(posedge mclk) disable iff (!rst_b)
      freeze_reg ##1 freeze_reg |-> !time_adv_reg)
      else $error("update while frozen");

   AST_UF_SET: assert property (@(posedge mclk) disable iff (!rst_b)
      time_adv_reg |=> uf_reg)
      else $error("update-done flag missing");

   AST_GATE_OFF: assert property (@(posedge mclk) disable iff (!rst_b)
      !pie_reg && !aie_reg && !uie_reg |=> !irq_reg)
      else $error("interrupt with all gates closed");

   AST_READ_CLR: assert property (@(posedge mclk) disable iff (!rst_b)
      rd_acc && idx == `RUF_IDX_FLAG && !per_evt && !alarm_evt && !time_adv_reg
      |=> (pf_reg == 1'b0 || !$past(snap_reg[2])) && (uf_reg == 1'b0 || !$past(snap_reg[0])))
      else $error("flag read did not clear");

   AST_UIP_RO: assert property (@(posedge mclk) disable iff (!rst_b)
      wr_acc && idx == `RUF_IDX_RATE && !wbyte[`RUF_A_UIP] && uip_reg && !time_adv_reg
      |=> uip_reg || !$past(uip_reg))
      else $error("write cleared pending flag");
endmodule : ruf_ctrl

// File: verilog/ruf_fmt.sv
`timescale 1ns/100ps
module ruf_fmt
(
   // mode bits
   input  wire logic       bin_mode,
   input  wire logic       h24,
   input  wire logic       is_hour,
   // internal binary value to host form
   input  wire logic [6:0] int_val,
   output logic      [7:0] ext_out,
   // host form to internal binary value
   input  wire logic [7:0] ext_in,
   output logic      [6:0] int_out
);
   function automatic logic [7:0] to_bcd(input logic [6:0] v);
      return {4'(v / 7'h0a), 4'(v % 7'h0a)};
   endfunction : to_bcd

   function automatic logic [6:0] from_bcd(input logic [7:0] b);
      return 7'(b[7:4] * 7'h0a) + 7'(b[3:0]);
   endfunction : from_bcd

   logic       twelve;
   logic [6:0] h;
   logic [7:0] v;
   logic [7:0] raw;
   logic [6:0] b;

   ////////////////////////////////////////////////////////////////////////////
   // read path: internal 0..23 hours become 1..12 plus pm bit
   always_comb
   begin
      twelve = is_hour && !h24;
      h      = int_val;
      if (twelve)
         h = (int_val == 7'h00) ? 7'h0c : (int_val > 7'h0c) ? int_val - 7'h0c : int_val;
      v = bin_mode ? {1'b0, h} : to_bcd(h);
      if (twelve)
         ext_out = {(int_val >= 7'h0c), v[6:0]};
      else
         ext_out = v;
   end

   ////////////////////////////////////////////////////////////////////////////
   // write path: storage stays binary 24-hour whatever the host uses
   always_comb
   begin
      raw     = twelve ? {1'b0, ext_in[6:0]} : ext_in;
      b       = bin_mode ? raw[6:0] : from_bcd(raw);
      int_out = b;
      if (twelve)
         int_out = (b == 7'h0c) ? (ext_in[7] ? 7'h0c : 7'h00)
                                : (ext_in[7] ? b + 7'h0c : b);
   end
endmodule : ruf_fmt

// File: verilog/ruf_pkg.sv
package ruf_pkg;
   // divider chain history, gray along stop -> run -> halt -> run
   typedef enum logic [1:0]
   {
      RUF_CH_STOP = 2'h0,
      RUF_CH_RUN  = 2'h1,
      RUF_CH_HALT = 2'h3
   } ruf_chain_t;
endpackage : ruf_pkg

// File: verilog/ruf_regs.svh
`ifndef RUF_REGS_SVH
`define RUF_REGS_SVH
// register indices; byte address is four times the index
`define RUF_IDX_RATE     4'ha
`define RUF_IDX_IRQF     4'hb
`define RUF_IDX_FLAG     4'hc
// rate/divider register fields
`define RUF_A_UIP        7
`define RUF_A_DCS        6:4
`define RUF_A_RATE       3:0
`define RUF_A_HALT       6:5
`define RUF_DCS_HALT     2:1
`define RUF_HALT_CODE    2'h3
// interrupt/format register fields
`define RUF_B_FREEZE     7
`define RUF_B_PIE        6
`define RUF_B_AIE        5
`define RUF_B_UIE        4
`define RUF_B_BIN        2
`define RUF_B_H24        1
`define RUF_B_DST        0
// flag register fields
`define RUF_C_IRQ        7
`define RUF_C_PF         6
`define RUF_C_AF         5
`define RUF_C_UF         4
// reset values and chain codes
`define RUF_RST_BYTE     8'h00
`define RUF_DCS_RUN      3'h2
`define RUF_DCS_RST      3'h0
// timing: tick rate in Hz, lead time in us, restart delay in ms
`define RUF_TICK_HZ      32'h8000
`define RUF_UIP_LEAD_US  32'h1e8
`define RUF_RESTART_MS   32'h1f4
`define RUF_UIP_LEAD_TICKS ((`RUF_UIP_LEAD_US * `RUF_TICK_HZ + 32'hf423f) / 32'hf4240)
`define RUF_RESTART_TICKS  ((`RUF_RESTART_MS * `RUF_TICK_HZ) / 32'h3e8)
`define RUF_DIV_TOP      15'h7fff
`endif

// File: verilog/ruf_sync2.sv
`timescale 1ns/100ps
module ruf_sync2
(
   // clock and reset
   input  wire logic mclk,
   input  wire logic rst_b,
   // async level in, synced level out
   input  wire logic d,
   output logic      q
);
   logic meta_reg;

   ////////////////////////////////////////////////////////////////////////////
   // two stages; only the second reads the first
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         meta_reg <= 1'b0;
         q        <= 1'b0;
      end
      else
      begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule : ruf_sync2
